// [pkg/intc_pkg.sv]
// Operation
// - Flag reads 1 while request pending, writable
// - Three-bit priority 1..7, zero disables source
// - Reset sets every source priority to 4
// - Nesting disable blocks pre-emption by user sources
// - Return restores previous CPU priority from stack for up to 8 nested levels, unless an acceptance falls in the same cycle
// - CPU priority 7 blocks all user sources
// - User levels maskable; traps 8-11 taken whenever above CPU priority
// - Timed mask blocks levels 1-6, not 7
// - Timed mask count is 14-bit unsigned
// - Group two flags at fixed bit positions
// - Without CAN, CAN sources never raise requests
`default_nettype none

package intc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_FLAGS2 = 8'h04;
  localparam logic [7:0] OFS_ENABLE2 = 8'h08;
  localparam logic [7:0] OFS_FLAGS_AUX = 8'h0c;
  localparam logic [7:0] OFS_ENABLE_AUX = 8'h10;
  localparam logic [7:0] OFS_PRIO_A = 8'h14;
  localparam logic [7:0] OFS_PRIO_B = 8'h18;
  localparam logic [7:0] OFS_PRIO_C = 8'h1c;
  localparam logic [7:0] OFS_CPU_PRIO = 8'h20;
  localparam logic [7:0] OFS_TIMED_MASK = 8'h24;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h28;
  localparam logic [7:0] OFS_EVT_MASK = 8'h2c;

  // ==========================================================================
  // Field layouts, implemented-bit masks and reset values
  localparam int NEST_BIT = 15;
  localparam int TRAP_LSB = 1;
  localparam int NUM_TRAPS = 4;
  localparam logic [15:0] CTRL_MASK = 16'h801e;
  localparam logic [15:0] FLAGS2_MASK = 16'h601f;
  localparam logic [15:0] CAN_BITS = 16'h000c;
  localparam logic [15:0] AUX_MASK = 16'h000f;
  localparam logic [15:0] PRIO_MASK_A = 16'h7777;
  localparam logic [15:0] PRIO_MASK_B = 16'h0777;
  localparam logic [15:0] PRIO_MASK_C = 16'h7777;
  localparam logic [15:0] PRIO_RST_A = 16'h4444;
  localparam logic [15:0] PRIO_RST_B = 16'h0444;
  localparam logic [15:0] PRIO_RST_C = 16'h4444;
  // Flag positions of sources 0..6: spi err, spi, can rx, can event, dma3, port, dma4
  localparam logic [27:0] G2_POS = {4'he, 4'hd, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
  localparam int NUM_SRC = 11;
  localparam int STACK_DEPTH = 8;
  localparam logic [2:0] LEVEL_TOP_USER = 3'h7;
  localparam logic [3:0] LEVEL_TRAP_BASE = 4'h8;
  localparam logic [4:0] TRAP_VEC_BASE = 5'h10;
  localparam int EVT_ACCEPT = 0;
  localparam int EVT_TRAP = 1;
  localparam int EVT_UNMASK = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int INSTR_CYCLE_NS = 8;
  localparam int INSTR_DIV = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [15:0] group2;
    logic [3:0] aux;
  } src_evt_t;

  typedef struct packed {
    logic valid;
    logic [4:0] vector;
    logic [3:0] level;
  } irq_req_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] flags2;
    logic [15:0] en2;
    logic [3:0] flags_aux;
    logic [3:0] en_aux;
    logic [2:0][15:0] prio;
    logic [3:0] cpu_prio;
    logic [STACK_DEPTH-1:0][3:0] stack;
    logic [3:0] depth;
    logic [13:0] mask_cnt;
    logic [7:0] div_cnt;
    logic [2:0] evt;
    logic [2:0] evt_mask;
    logic aw_full;
    logic [11:0] aw_addr;
    logic w_full;
    logic [15:0] w_data;
    logic [1:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    irq_req_t req;
  } state_t;

endpackage

`default_nettype wire

// [hdl/interrupt_priority_flag_logic.sv]
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`default_nettype none

module interrupt_priority_flag_logic #(
  parameter bit HAS_CAN = 1'b1,
  parameter int INSTR_DIV = intc_pkg::INSTR_DIV
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Peripheral events and trap conditions
  input wire intc_pkg::src_evt_t src_evt,
  input wire logic [3:0] trap_req,
  // Processor core side
  output intc_pkg::irq_req_t irq_req,
  input wire logic irq_ack,
  input wire logic return_from_interrupt,
  output logic [3:0] cpu_prio,
  // Block event interrupt
  output logic irq_out
);

  // ==========================================================================
  // Reset image and working signals
  localparam intc_pkg::state_t ST_RESET = '{
    prio: {intc_pkg::PRIO_RST_C, intc_pkg::PRIO_RST_B, intc_pkg::PRIO_RST_A},
    default: '0
  };
  localparam logic [15:0] CAN_KEEP = HAS_CAN ? 16'hffff : ~intc_pkg::CAN_BITS;
  localparam logic [7:0] DIV_LAST = 8'(INSTR_DIV - 1);

  intc_pkg::state_t s_q, s_d;
  logic tick, wr_en, wr_hit, rd_hit;
  logic [15:0] wr_val, rd_val, g2_mask;
  // Declared ahead of the source vectors that are sized by it
  localparam int NUM_SRC_W = intc_pkg::NUM_SRC;
  logic [NUM_SRC_W-1:0] flag_vec, en_vec;
  logic [2:0] lvl;
  logic [3:0] best_lvl, top_prio;
  logic [4:0] best_vec;
  logic best_found, timed_on, nest_block;

  // Byte-lane merge of a write into a register, unimplemented bits stay zero
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic [1:0] strb, input logic [15:0] msk);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = nw[7:0];
    if (strb[1]) r[15:8] = nw[15:8];
    return r & msk;
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    g2_mask = intc_pkg::FLAGS2_MASK & CAN_KEEP;
    top_prio = s_q.stack[s_q.depth[2:0] - 3'h1];

    // Instruction-cycle enable from the system clock
    tick = s_q.div_cnt == DIV_LAST;
    s_d.div_cnt = tick ? 8'h00 : s_q.div_cnt + 8'h01;

    // Address and data are taken independently, in either order
    if (awvalid && !s_q.aw_full) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && !s_q.w_full) begin
      s_d.w_full = 1'b1;
      s_d.w_data = wdata[15:0];
      s_d.w_strb = wstrb[1:0];
    end
    if (s_q.bvalid && bready) s_d.bvalid = 1'b0;

    // Register write once both halves are held and no response is pending
    wr_en = s_q.aw_full && s_q.w_full && !s_q.bvalid;
    wr_val = s_q.w_data;
    // Unmapped or unaligned writes answer with an error and change nothing
    wr_hit = s_q.aw_addr[11:8] == 4'h0 && s_q.aw_addr[1:0] == 2'h0;
    if (wr_en) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      unique case (wr_hit ? s_q.aw_addr[7:0] : 8'hff)
        intc_pkg::OFS_CTRL_ONE:
          s_d.ctrl = merge(s_q.ctrl, wr_val, s_q.w_strb, intc_pkg::CTRL_MASK);
        intc_pkg::OFS_FLAGS2:
          s_d.flags2 = merge(s_q.flags2, wr_val, s_q.w_strb, g2_mask);
        intc_pkg::OFS_ENABLE2:
          s_d.en2 = merge(s_q.en2, wr_val, s_q.w_strb, g2_mask);
        intc_pkg::OFS_FLAGS_AUX:
          s_d.flags_aux = 4'(merge({12'h000, s_q.flags_aux}, wr_val, s_q.w_strb,
                                   intc_pkg::AUX_MASK));
        intc_pkg::OFS_ENABLE_AUX:
          s_d.en_aux = 4'(merge({12'h000, s_q.en_aux}, wr_val, s_q.w_strb,
                                intc_pkg::AUX_MASK));
        intc_pkg::OFS_PRIO_A:
          s_d.prio[0] = merge(s_q.prio[0], wr_val, s_q.w_strb, intc_pkg::PRIO_MASK_A);
        intc_pkg::OFS_PRIO_B:
          s_d.prio[1] = merge(s_q.prio[1], wr_val, s_q.w_strb, intc_pkg::PRIO_MASK_B);
        intc_pkg::OFS_PRIO_C:
          s_d.prio[2] = merge(s_q.prio[2], wr_val, s_q.w_strb, intc_pkg::PRIO_MASK_C);
        intc_pkg::OFS_CPU_PRIO:
          if (s_q.w_strb[0]) s_d.cpu_prio = {1'b0, wr_val[2:0]};
        intc_pkg::OFS_TIMED_MASK:
          if (&s_q.w_strb) s_d.mask_cnt = wr_val[13:0];
        intc_pkg::OFS_EVT_MASK:
          if (s_q.w_strb[0]) s_d.evt_mask = wr_val[2:0];
        default: wr_hit = 1'b0;
      endcase
      s_d.bresp = wr_hit ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
    end

    // Register read, answered the cycle after the address is taken
    rd_hit = araddr[11:8] == 4'h0 && araddr[1:0] == 2'h0;
    unique case (araddr[7:0])
      intc_pkg::OFS_CTRL_ONE: rd_val = s_q.ctrl;
      intc_pkg::OFS_FLAGS2: rd_val = s_q.flags2;
      intc_pkg::OFS_ENABLE2: rd_val = s_q.en2;
      intc_pkg::OFS_FLAGS_AUX: rd_val = {12'h000, s_q.flags_aux};
      intc_pkg::OFS_ENABLE_AUX: rd_val = {12'h000, s_q.en_aux};
      intc_pkg::OFS_PRIO_A: rd_val = s_q.prio[0];
      intc_pkg::OFS_PRIO_B: rd_val = s_q.prio[1];
      intc_pkg::OFS_PRIO_C: rd_val = s_q.prio[2];
      intc_pkg::OFS_CPU_PRIO: rd_val = {12'h000, s_q.cpu_prio};
      intc_pkg::OFS_TIMED_MASK: rd_val = {2'h0, s_q.mask_cnt};
      intc_pkg::OFS_EVT_STATUS: rd_val = {13'h0000, s_q.evt};
      intc_pkg::OFS_EVT_MASK: rd_val = {13'h0000, s_q.evt_mask};
      default: begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
    if (s_q.rvalid && rready) s_d.rvalid = 1'b0;
    if (arvalid && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd_hit ? {16'h0000, rd_val} : 32'h0000_0000;
      s_d.rresp = rd_hit ? intc_pkg::RESP_OKAY : intc_pkg::RESP_SLVERR;
      if (rd_hit && araddr[7:0] == intc_pkg::OFS_EVT_STATUS) s_d.evt = 3'h0;
    end

    // Return pops the priority saved when the interrupt was accepted
    if (return_from_interrupt && s_q.depth != 4'h0) begin
      s_d.cpu_prio = top_prio;
      s_d.depth = s_q.depth - 4'h1;
    end

    // Accepting a request saves the old priority unless the stack is full, and runs at the new level
    if (irq_ack && s_q.req.valid) begin
      if (s_q.depth != 4'(intc_pkg::STACK_DEPTH)) begin
        s_d.stack[s_q.depth[2:0]] = s_q.cpu_prio;
        s_d.depth = s_q.depth + 4'h1;
      end
      s_d.cpu_prio = s_q.req.level;
      s_d.evt[intc_pkg::EVT_ACCEPT] = 1'b1;
    end

    // Timed mask counts down in instruction cycles
    if (s_q.mask_cnt != 14'h0000 && tick && !(wr_en && wr_hit && &s_q.w_strb &&
        s_q.aw_addr[7:0] == intc_pkg::OFS_TIMED_MASK)) begin
      s_d.mask_cnt = s_q.mask_cnt - 14'h0001;
      if (s_q.mask_cnt == 14'h0001) s_d.evt[intc_pkg::EVT_UNMASK] = 1'b1;
    end

    // Hardware sets come last so a same-cycle clear never loses an event
    s_d.flags2 = s_d.flags2 | (src_evt.group2 & g2_mask);
    s_d.flags_aux = s_d.flags_aux | src_evt.aux;
    s_d.ctrl[intc_pkg::TRAP_LSB +: intc_pkg::NUM_TRAPS] =
      s_d.ctrl[intc_pkg::TRAP_LSB +: intc_pkg::NUM_TRAPS] | trap_req;
    if (|trap_req) s_d.evt[intc_pkg::EVT_TRAP] = 1'b1;

    // Flags stay set after acceptance, so an uncleared source is retaken
    for (int k = 0; k < 7; k++) begin
      flag_vec[k] = s_q.flags2[intc_pkg::G2_POS[k*4 +: 4]];
      en_vec[k] = s_q.en2[intc_pkg::G2_POS[k*4 +: 4]];
    end
    flag_vec[10:7] = s_q.flags_aux;
    en_vec[10:7] = s_q.en_aux;

    // Arbitration over user sources; ties go to the lower source number
    timed_on = s_q.mask_cnt != 14'h0000;
    nest_block = s_q.ctrl[intc_pkg::NEST_BIT] && s_q.depth != 4'h0;
    best_found = 1'b0;
    best_lvl = 4'h0;
    best_vec = 5'h00;
    lvl = 3'h0;
    for (int k = 0; k < intc_pkg::NUM_SRC; k++) begin
      // Aux sources use the third priority register, not the tail of the second
      if (k < 7) begin
        lvl = s_q.prio[k / 4][(k % 4) * 4 +: 3];
      end else begin
        lvl = s_q.prio[2][(k - 7) * 4 +: 3];
      end
      if (flag_vec[k] && en_vec[k] && lvl != 3'h0 && !nest_block
          && {1'b0, lvl} > s_q.cpu_prio
          && !(timed_on && lvl != intc_pkg::LEVEL_TOP_USER)
          && {1'b0, lvl} > best_lvl) begin
        best_found = 1'b1;
        best_lvl = {1'b0, lvl};
        best_vec = 5'(k);
      end
    end

    // Traps sit above every user level and ignore all masking
    for (int i = 0; i < intc_pkg::NUM_TRAPS; i++) begin
      if (s_q.ctrl[intc_pkg::TRAP_LSB + i] &&
          intc_pkg::LEVEL_TRAP_BASE + 4'(i) > s_q.cpu_prio) begin
        best_found = 1'b1;
        best_lvl = intc_pkg::LEVEL_TRAP_BASE + 4'(i);
        best_vec = intc_pkg::TRAP_VEC_BASE + 5'(i);
      end
    end

    // Offer is withdrawn for one cycle after acceptance to let priority settle
    s_d.req.valid = best_found && !(irq_ack && s_q.req.valid);
    s_d.req.vector = best_vec;
    s_d.req.level = best_lvl;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= ST_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign awready = !s_q.aw_full;
  assign wready = !s_q.w_full;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = !s_q.rvalid;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign irq_req = s_q.req;
  assign cpu_prio = s_q.cpu_prio;
  // Level output, high while any unmasked event bit is set
  assign irq_out = |(s_q.evt & s_q.evt_mask);

  // ==========================================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_RESET_PRIO: assert property ($past(!aresetn) |-> s_q.prio[0] == 16'h4444)
    else $error("priority fields not at level 4 after reset");
  AST_FLAG_SET: assert property (src_evt.group2[14] |=> s_q.flags2[14])
    else $error("dma4 event did not set its flag");
  AST_UNIMPL: assert property ((s_q.flags2 & ~16'h601f) == 16'h0000)
    else $error("unimplemented flag bit set");
  AST_LEVEL_NZ: assert property (s_q.req.valid |-> s_q.req.level != 4'h0)
    else $error("request offered at level zero");
  AST_NEST: assert property ((s_q.ctrl[15] && s_q.depth != 4'h0 && s_q.req.valid
      && $past(s_q.depth) != 4'h0 && $past(s_q.ctrl[15])) |-> s_q.req.level >= 4'h8)
    else $error("user source pre-empted with nesting disabled");
  AST_RETURN: assert property ((return_from_interrupt && s_q.depth != 4'h0
      && !(irq_ack && s_q.req.valid)) |=> s_q.cpu_prio == $past(top_prio))
    else $error("return did not restore saved priority");
  AST_PRIO7: assert property (($past(s_q.cpu_prio) == 4'h7 && s_q.req.valid)
      |-> s_q.req.level >= 4'h8)
    else $error("user request offered at cpu priority 7");
  AST_TRAP: assert property ((s_q.ctrl[1] && s_q.cpu_prio < 4'h8 && !irq_ack)
      |=> s_q.req.valid && s_q.req.level >= 4'h8)
    else $error("pending trap not offered");
  AST_TIMED: assert property (($past(s_q.mask_cnt) != 14'h0000 && s_q.req.valid
      && s_q.req.level < 4'h8) |-> s_q.req.level == 4'h7)
    else $error("level below 7 offered during timed mask");
  AST_COUNT: assert property ((wr_en && wr_hit && s_q.aw_addr[7:0] == 8'h24
      && &s_q.w_strb) |=> s_q.mask_cnt == $past(s_q.w_data[13:0]))
    else $error("timed mask count not loaded");
  AST_NO_CAN: assert property (!HAS_CAN |-> s_q.flags2[3:2] == 2'h0)
    else $error("can flag set without can");

endmodule // interrupt_priority_flag_logic

`default_nettype wire

// [verif/core_model.sv]
`default_nettype none

// ==========================================================================
// Core model: takes offers after a set delay, returns on command
module core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller side
  input wire intc_pkg::irq_req_t irq_req,
  output logic irq_ack,
  output logic return_from_interrupt,
  // Bench side
  input wire logic ack_en,
  input wire logic [3:0] ack_dly,
  input wire logic ret_go,
  output logic [4:0] taken_vec,
  output logic [7:0] taken_cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] wait_q;

  // Ack is one pulse; the wait restarts after it, so one offer is taken once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ack <= 1'b0;
      return_from_interrupt <= 1'b0;
      wait_q <= 4'h0;
      taken_vec <= 5'h00;
      taken_cnt <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      return_from_interrupt <= ret_go;
      if (irq_ack || !irq_req.valid || !ack_en) begin
        wait_q <= 4'h0;
      end else if (wait_q < ack_dly) begin
        wait_q <= wait_q + 4'h1;
      end else begin
        irq_ack <= 1'b1;
        taken_vec <= irq_req.vector;
        taken_cnt <= taken_cnt + 8'h01;
      end
    end
  end

endmodule // core_model

`default_nettype wire

// [verif/testbench.sv]
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack_en, ret_go;
  logic awready, wready, bvalid, arready, rvalid, irq_ack, ret_pulse, irq_out;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, last_rd;
  logic [3:0] wstrb, trap_req, ack_dly, cpu_prio;
  logic [1:0] bresp, rresp, last_resp;
  logic [4:0] taken_vec;
  logic [7:0] taken_cnt;
  intc_pkg::src_evt_t src_evt;
  intc_pkg::irq_req_t irq_req;
  int err_total, num_checks;

  // Clock, 4 ns period
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  interrupt_priority_flag_logic #(.HAS_CAN(1'b1), .INSTR_DIV(2)) u_interrupt_priority_flag_logic (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .src_evt(src_evt),
    .trap_req(trap_req), .irq_req(irq_req), .irq_ack(irq_ack),
    .return_from_interrupt(ret_pulse), .cpu_prio(cpu_prio), .irq_out(irq_out));

  core_model u_core_model (
    .aclk(aclk), .aresetn(aresetn), .irq_req(irq_req), .irq_ack(irq_ack),
    .return_from_interrupt(ret_pulse), .ack_en(ack_en), .ack_dly(ack_dly), .ret_go(ret_go),
    .taken_vec(taken_vec), .taken_cnt(taken_cnt));

  // ==========================================================================
  // Reporting
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // A wait that runs out ends the run at once
  task automatic hang(input string msg);
    err_total++;
    $display("Error at %0t: %s timed out", $time, msg);
    results();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // ==========================================================================
  // Bus tasks: handshakes are judged on the values sampled at the edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {4'h0, a};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (n > 50) hang("write");
    end while (!(bvalid === 1'b1));
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {4'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (n > 50) hang("read");
    end while (!(rvalid === 1'b1));
    last_rd = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
    rd(a);
    chk(last_rd, e, m);
  endtask

  // Offer seen after the one-cycle recompute; only valid matters when none is due
  task automatic offer(input logic v, input logic [4:0] vec, input logic [3:0] lv, input string m);
    cyc(4);
    chk(v ? {22'h0, irq_req} : {31'h0, irq_req.valid}, {22'h0, v, vec, lv}, m);
  endtask

  task automatic take(input logic [3:0] d);
    logic [7:0] c;
    int n;
    c = taken_cnt;
    n = 0;
    @(posedge aclk);
    ack_dly <= d;
    ack_en <= 1'b1;
    while (taken_cnt === c) begin
      @(posedge aclk);
      n++;
      if (n > 50) hang("ack");
    end
    ack_en <= 1'b0;
    cyc(2);
  endtask

  task automatic ret();
    @(posedge aclk);
    ret_go <= 1'b1;
    @(posedge aclk);
    ret_go <= 1'b0;
    cyc(3);
  endtask

  task automatic pulse(input logic [15:0] g, input logic [3:0] t);
    @(posedge aclk);
    src_evt.group2 <= g;
    trap_req <= t;
    @(posedge aclk);
    src_evt.group2 <= 16'h0000;
    trap_req <= 4'h0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    chk({28'h0, cpu_prio}, 32'h0, "cpu prio reset");
    rdc(intc_pkg::OFS_PRIO_A, 32'h4444, "prio a reset");
    rdc(intc_pkg::OFS_PRIO_B, 32'h0444, "prio b reset");
    rdc(intc_pkg::OFS_PRIO_C, 32'h4444, "prio c reset");
    pulse(16'hffff, 4'h0);
    rdc(intc_pkg::OFS_FLAGS2, 32'h601f, "flag positions");
    wr(intc_pkg::OFS_FLAGS2, 16'h0000);
    rdc(intc_pkg::OFS_FLAGS2, 32'h0, "flags cleared");
    wr(intc_pkg::OFS_FLAGS2, 16'hffff);
    rdc(intc_pkg::OFS_FLAGS2, 32'h601f, "flags written");
    wr(intc_pkg::OFS_PRIO_A, 16'hffff);
    rdc(intc_pkg::OFS_PRIO_A, 32'h7777, "prio unused bits");
    wr(intc_pkg::OFS_FLAGS2, 16'h0000);
    $display("test regs done");
  endtask

  task automatic t_arb();
    wr(intc_pkg::OFS_PRIO_A, 16'h0053);
    wr(intc_pkg::OFS_FLAGS2, 16'h0000);
    wr(intc_pkg::OFS_ENABLE2, 16'h0003);
    wr(intc_pkg::OFS_FLAGS2, 16'h0003);
    offer(1'b1, 5'h01, 4'h5, "highest wins");
    wr(intc_pkg::OFS_PRIO_A, 16'h0003);
    offer(1'b1, 5'h00, 4'h3, "zero disables");
    wr(intc_pkg::OFS_PRIO_A, 16'h0033);
    offer(1'b1, 5'h00, 4'h3, "equal levels");
    wr(intc_pkg::OFS_PRIO_A, 16'h0053);
    wr(intc_pkg::OFS_FLAGS2, 16'h0001);
    take(4'h3);
    chk({28'h0, cpu_prio}, 32'h3, "accepted level");
    chk({27'h0, taken_vec}, 32'h0, "accepted vector");
    wr(intc_pkg::OFS_FLAGS2, 16'h0003);
    offer(1'b1, 5'h01, 4'h5, "pre-emption");
    wr(intc_pkg::OFS_CTRL_ONE, 16'h8000);
    offer(1'b0, 5'h00, 4'h0, "nesting off");
    wr(intc_pkg::OFS_CTRL_ONE, 16'h0000);
    wr(intc_pkg::OFS_FLAGS2, 16'h0001);
    ret();
    chk({28'h0, cpu_prio}, 32'h0, "level restored");
    offer(1'b1, 5'h00, 4'h3, "retaken");
    wr(intc_pkg::OFS_FLAGS2, 16'h0000);
    offer(1'b0, 5'h00, 4'h0, "cleared flag");
    // Timer five is aux source 0, vector 7, priority in bits 2:0 of the third word
    wr(intc_pkg::OFS_PRIO_C, 16'h0005);
    wr(intc_pkg::OFS_FLAGS_AUX, 16'h0000);
    wr(intc_pkg::OFS_ENABLE_AUX, 16'h0001);
    @(posedge aclk);
    src_evt.aux <= 4'h1;
    @(posedge aclk);
    src_evt.aux <= 4'h0;
    offer(1'b1, 5'h07, 4'h5, "aux source");
    wr(intc_pkg::OFS_FLAGS_AUX, 16'h0000);
    $display("test arbitration done");
  endtask

  task automatic t_trap();
    wr(intc_pkg::OFS_PRIO_A, 16'h0073);
    wr(intc_pkg::OFS_CPU_PRIO, 16'h0007);
    wr(intc_pkg::OFS_FLAGS2, 16'h0002);
    offer(1'b0, 5'h00, 4'h0, "cpu level seven");
    chk({28'h0, cpu_prio}, 32'h7, "cpu prio port");
    pulse(16'h0000, 4'h2);
    offer(1'b1, 5'h11, 4'h9, "trap taken");
    rdc(intc_pkg::OFS_CTRL_ONE, 32'h0004, "trap flag");
    wr(intc_pkg::OFS_CTRL_ONE, 16'h0000);
    offer(1'b0, 5'h00, 4'h0, "trap cleared");
    wr(intc_pkg::OFS_CPU_PRIO, 16'h0000);
    offer(1'b1, 5'h01, 4'h7, "unmasked");
    wr(intc_pkg::OFS_FLAGS2, 16'h0000);
    $display("test trap done");
  endtask

  // Count 0xc010 keeps 14 bits: 16 instruction cycles, 32 clocks
  task automatic t_timed();
    int n;
    wr(intc_pkg::OFS_PRIO_A, 16'h0076);
    wr(intc_pkg::OFS_TIMED_MASK, 16'hc010);
    wr(intc_pkg::OFS_FLAGS2, 16'h0001);
    offer(1'b0, 5'h00, 4'h0, "level six masked");
    wr(intc_pkg::OFS_FLAGS2, 16'h0003);
    offer(1'b1, 5'h01, 4'h7, "level seven passes");
    wr(intc_pkg::OFS_FLAGS2, 16'h0001);
    // The level seven offer still stands for one edge after the write
    cyc(2);
    n = 0;
    while (irq_req.valid !== 1'b1) begin
      @(posedge aclk);
      n++;
      if (n > 60) hang("timed mask");
    end
    chk({22'h0, irq_req}, {22'h0, 1'b1, 5'h00, 4'h6}, "mask over");
    $display("test timed mask done");
  endtask

  task automatic t_evt();
    wr(intc_pkg::OFS_EVT_MASK, 16'h0004);
    cyc(2);
    chk({31'h0, irq_out}, 32'h1, "event raised");
    rdc(intc_pkg::OFS_EVT_STATUS, 32'h0007, "event status");
    cyc(2);
    chk({31'h0, irq_out}, 32'h0, "read clears");
    wr(intc_pkg::OFS_EVT_MASK, 16'h0001);
    take(4'h0);
    chk({31'h0, irq_out}, 32'h1, "accept event");
    wr(intc_pkg::OFS_EVT_MASK, 16'h0000);
    cyc(2);
    chk({31'h0, irq_out}, 32'h0, "masked");
    rd(intc_pkg::OFS_EVT_STATUS);
    ret();
    wr(intc_pkg::OFS_FLAGS2, 16'h0000);
    wr(8'h30, 16'h1234);
    chk({30'h0, last_resp}, {30'h0, intc_pkg::RESP_SLVERR}, "unmapped write");
    rd(8'h02);
    chk({30'h0, last_resp}, {30'h0, intc_pkg::RESP_SLVERR}, "unaligned read");
    chk(last_rd, 32'h0, "unaligned data");
    $display("test events done");
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    err_total = 0;
    num_checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, ack_en, ret_go} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hf;
    trap_req = 4'h0;
    ack_dly = 4'h0;
    src_evt = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_arb();
    t_trap();
    t_timed();
    t_evt();
    results();
  end

endmodule // testbench

`default_nettype wire
